// ===== verilog/ffop_pkg.sv
// package of constants for the fifo flag offset programming block
package ffop_pkg;
   // avalon register byte offsets
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_EMPTY_OFFSET = 4'h8;
   localparam logic [3:0] ADDR_FULL_OFFSET = 4'hC;
   // config register fields
   localparam int CFG_X9_BOTH = 0;
   localparam int CFG_DEPTH_LO = 1;
   localparam int CFG_SYNC_FLAGS = 3;
   localparam int CFG_FIRST_WORD_FALL_THROUGH_MODE = 4;
   localparam int CFG_W = 5;
   localparam logic [4:0] CFG_RESET = 5'h08;
   // status register fields
   localparam int ST_SERIAL_MODE = 0;
   localparam int ST_AE_VALID = 1;
   localparam int ST_AF_VALID = 2;
   localparam int ST_COUNT_LO = 3;
   // offset register geometry
   localparam int OFF_W = 17;
   localparam int LOW_PART_W = 8;
   localparam int HIGH_PART_W = 9;
   localparam int CNT_W = 6;
   localparam logic [5:0] BITS_X9_BASE = 6'h0E;
   localparam logic [5:0] BITS_OTHER_BASE = 6'h0D;
   // parallel part pointer order
   localparam logic [1:0] PART_EMPTY_LOW = 2'h0;
   localparam logic [1:0] PART_EMPTY_HIGH = 2'h1;
   localparam logic [1:0] PART_FULL_LOW = 2'h2;
   localparam logic [1:0] PART_FULL_HIGH = 2'h3;
   // clock edges from load completion to flag validity
   localparam logic [1:0] FLAG_EDGES = 2'h2;
   // pin vector layout through the synchronisers
   localparam int PIN_WCLK = 0;
   localparam int PIN_RCLK = 1;
   localparam int PIN_LD = 2;
   localparam int PIN_WEN = 3;
   localparam int PIN_REN = 4;
   localparam int PIN_SEN = 5;
   localparam int PIN_SI = 6;
   localparam int PIN_DATA = 7;
endpackage : ffop_pkg

// ===== verilog/ffop_offset_ctrl.sv
// offset register load, shift and readback control with avalon status port
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ffop_offset_ctrl #(
   parameter int DW = 18
) (
   // clock and master reset
   input wire logic core_clk,
   input wire logic reset,
   // strap sampled during master reset
   input wire logic serial_mode_strap,
   // fifo pins
   input wire logic write_clk_pin,
   input wire logic read_clk_pin,
   input wire logic offset_load_select_n,
   input wire logic write_enable_n,
   input wire logic read_enable_n,
   input wire logic serial_shift_enable_n,
   input wire logic serial_in,
   input wire logic [DW-1:0] data_inputs,
   output logic [DW-1:0] data_outputs,
   // memory access strobes
   output logic mem_write,
   output logic [DW-1:0] mem_write_data,
   output logic mem_read,
   // flag validity
   output logic almost_empty_valid,
   output logic almost_full_valid,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest
);
   localparam int PW = ffop_pkg::PIN_DATA + DW;

   typedef struct packed {
      logic [PW-1:0] s1;
      logic [PW-1:0] s2;
      logic [PW-1:0] s3;
      logic wclk_st;
      logic rclk_st;
      logic serial_mode;
      logic [ffop_pkg::CFG_W-1:0] cfg;
      logic [ffop_pkg::OFF_W-1:0] empty_off;
      logic [ffop_pkg::OFF_W-1:0] full_off;
      logic [1:0] wptr;
      logic [1:0] rptr;
      logic [ffop_pkg::CNT_W-1:0] cnt;
      logic [1:0] af_cnt;
      logic [1:0] ae_cnt;
      logic ae_valid;
      logic af_valid;
      logic [DW-1:0] q;
      logic mem_wr;
      logic mem_rd;
      logic [DW-1:0] mem_wdata;
      logic ack;
      logic [31:0] rdata;
   } ffop_state_s;

   ffop_state_s st;
   ffop_state_s next_st;

   // bits per offset register for this width mix and depth
   function automatic logic [ffop_pkg::CNT_W-1:0] reg_bits(input logic x9, input logic [1:0] d);
      reg_bits = (x9 ? ffop_pkg::BITS_X9_BASE : ffop_pkg::BITS_OTHER_BASE) + {4'h0, d};
   endfunction : reg_bits

   // edge counts once the second and third stages agree
   function automatic logic rise(input logic a, input logic b, input logic stable);
      rise = (a == b) && b && !stable;
   endfunction : rise

   logic [PW-1:0] pins;
   logic w_edge;
   logic r_edge;
   logic ld_n;
   logic wen_n;
   logic ren_n;
   logic sen_n;
   logic [DW-1:0] din;
   logic [ffop_pkg::CNT_W-1:0] nbits;
   logic [ffop_pkg::CNT_W-1:0] total;
   logic par_wr;
   logic par_rd;
   logic ser;
   logic mem_w;
   logic mem_r;
   logic ser_done;
   logic par_done;
   logic req;
   logic [ffop_pkg::CNT_W-1:0] fidx;

   always_comb begin
      pins = {data_inputs, serial_in, serial_shift_enable_n, read_enable_n, write_enable_n,
              offset_load_select_n, read_clk_pin, write_clk_pin};
      w_edge = rise(st.s2[ffop_pkg::PIN_WCLK], st.s3[ffop_pkg::PIN_WCLK], st.wclk_st);
      r_edge = rise(st.s2[ffop_pkg::PIN_RCLK], st.s3[ffop_pkg::PIN_RCLK], st.rclk_st);
      ld_n = st.s3[ffop_pkg::PIN_LD];
      wen_n = st.s3[ffop_pkg::PIN_WEN];
      ren_n = st.s3[ffop_pkg::PIN_REN];
      sen_n = st.s3[ffop_pkg::PIN_SEN];
      din = st.s3[ffop_pkg::PIN_DATA +: DW];
      // fall-through selection never enters the decode below
      nbits = reg_bits(st.cfg[ffop_pkg::CFG_X9_BOTH], st.cfg[ffop_pkg::CFG_DEPTH_LO +: 2]);
      total = nbits + nbits;
      fidx = st.cnt - nbits;
      // the three offset actions need the other enables high
      par_wr = w_edge && !ld_n && !wen_n && ren_n && sen_n && !st.serial_mode;
      par_rd = r_edge && !ld_n && wen_n && !ren_n && sen_n;
      ser = w_edge && !ld_n && wen_n && ren_n && !sen_n && st.serial_mode;
      mem_w = w_edge && ld_n && !wen_n;
      mem_r = r_edge && ld_n && !ren_n;
      ser_done = ser && (st.cnt == total - 6'h01);
      par_done = par_wr && (st.wptr == ffop_pkg::PART_FULL_HIGH);
      req = read || write;
   end

   always_comb begin
      next_st = st;
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2[ffop_pkg::PIN_WCLK] == st.s3[ffop_pkg::PIN_WCLK]) begin
         next_st.wclk_st = st.s3[ffop_pkg::PIN_WCLK];
      end
      if (st.s2[ffop_pkg::PIN_RCLK] == st.s3[ffop_pkg::PIN_RCLK]) begin
         next_st.rclk_st = st.s3[ffop_pkg::PIN_RCLK];
      end
      next_st.mem_wr = mem_w;
      next_st.mem_rd = mem_r;
      if (mem_w) begin
         next_st.mem_wdata = din;
      end
      // parallel write, pointer wraps back to empty low
      if (par_wr) begin
         case (st.wptr)
            ffop_pkg::PART_EMPTY_LOW: next_st.empty_off[7:0] = din[7:0];
            ffop_pkg::PART_EMPTY_HIGH: next_st.empty_off[16:8] = din[16:8];
            ffop_pkg::PART_FULL_LOW: next_st.full_off[7:0] = din[7:0];
            ffop_pkg::PART_FULL_HIGH: next_st.full_off[16:8] = din[16:8];
            default: next_st.wptr = st.wptr;
         endcase
         next_st.wptr = st.wptr + 2'h1;
      end
      // readback overwrites the word on the outputs
      if (par_rd) begin
         case (st.rptr)
            ffop_pkg::PART_EMPTY_LOW: next_st.q = {{(DW-8){1'b0}}, st.empty_off[7:0]};
            ffop_pkg::PART_EMPTY_HIGH: next_st.q = {{(DW-9){1'b0}}, st.empty_off[16:8]};
            ffop_pkg::PART_FULL_LOW: next_st.q = {{(DW-8){1'b0}}, st.full_off[7:0]};
            ffop_pkg::PART_FULL_HIGH: next_st.q = {{(DW-9){1'b0}}, st.full_off[16:8]};
            default: next_st.q = st.q;
         endcase
         next_st.rptr = st.rptr + 2'h1;
      end
      // serial bits go empty lsb first then full; counter survives interruptions
      if (ser) begin
         // a fresh load clears both registers, so bits beyond this depth read as zero
         if (st.cnt == '0) begin
            next_st.empty_off = '0;
            next_st.full_off = '0;
         end
         if (st.cnt < nbits) begin
            next_st.empty_off[st.cnt[4:0]] = st.s3[ffop_pkg::PIN_SI];
         end else begin
            next_st.full_off[fidx[4:0]] = st.s3[ffop_pkg::PIN_SI];
         end
         next_st.cnt = ser_done ? '0 : st.cnt + 6'h01;
      end
      if (st.af_cnt != '0 && w_edge) begin
         next_st.af_cnt = st.af_cnt - 2'h1;
         next_st.af_valid = (st.af_cnt == 2'h1);
      end
      if (st.ae_cnt != '0 && r_edge) begin
         next_st.ae_cnt = st.ae_cnt - 2'h1;
         next_st.ae_valid = (st.ae_cnt == 2'h1);
      end
      // any offset load start makes both flags invalid; placed after the countdown
      // so a restart inside the two settling edges cannot leave a flag going valid
      if ((ser && st.cnt == '0) || (par_wr && st.wptr == ffop_pkg::PART_EMPTY_LOW)) begin
         next_st.ae_valid = 1'b0;
         next_st.af_valid = 1'b0;
         next_st.ae_cnt = '0;
         next_st.af_cnt = '0;
      end
      if (ser_done || par_done) begin
         next_st.af_cnt = ffop_pkg::FLAG_EDGES;
         next_st.ae_cnt = ffop_pkg::FLAG_EDGES;
         next_st.af_valid = 1'b0;
         next_st.ae_valid = 1'b0;
      end
      // one wait cycle, read data ready when waitrequest drops
      next_st.ack = req && !st.ack;
      if (req && !st.ack) begin
         case (address)
            ffop_pkg::ADDR_CONFIG: next_st.rdata = {27'h0, st.cfg};
            ffop_pkg::ADDR_STATUS: next_st.rdata = {23'h0, st.cnt, st.af_valid, st.ae_valid,
                                                   st.serial_mode};
            ffop_pkg::ADDR_EMPTY_OFFSET: next_st.rdata = {15'h0, st.empty_off};
            ffop_pkg::ADDR_FULL_OFFSET: next_st.rdata = {15'h0, st.full_off};
            default: next_st.rdata = 32'h0;
         endcase
      end
      if (write && st.ack && address == ffop_pkg::ADDR_CONFIG) begin
         next_st.cfg = writedata[ffop_pkg::CFG_W-1:0];
      end
      if (reset) begin
         next_st = '0;
         next_st.cfg = ffop_pkg::CFG_RESET;
         next_st.wptr = ffop_pkg::PART_EMPTY_LOW;
         next_st.rptr = ffop_pkg::PART_EMPTY_LOW;
         // method is taken from the strap only while master reset is held
         next_st.serial_mode = serial_mode_strap;
      end
   end

   always_ff @(posedge core_clk) begin
      st <= next_st;
   end

   // offsets leave only through the parallel outputs and the status port
   assign data_outputs = st.q;
   assign mem_write = st.mem_wr;
   assign mem_write_data = st.mem_wdata;
   assign mem_read = st.mem_rd;
   assign almost_empty_valid = st.ae_valid;
   assign almost_full_valid = st.af_valid;
   assign readdata = st.rdata;
   assign waitrequest = req && !st.ack;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_PWRITE: assert property (par_wr && st.wptr == ffop_pkg::PART_FULL_LOW |=>
      st.full_off[7:0] == $past(din[7:0]) && st.wptr == ffop_pkg::PART_FULL_HIGH)
      else $error("parallel offset write went to the wrong part");
   AST_PREAD: assert property (par_rd && st.rptr == ffop_pkg::PART_EMPTY_HIGH |=>
      data_outputs[8:0] == $past(st.empty_off[16:8]))
      else $error("parallel offset read gave the wrong part");
   AST_SHIFT0: assert property (ser && st.cnt == '0 |=>
      st.empty_off[0] == $past(st.s3[ffop_pkg::PIN_SI]) && st.cnt == 6'h01)
      else $error("first serial bit not in empty lsb");
   AST_WRAP: assert property (ser && st.cnt == total - 6'h01 |=> st.cnt == '0)
      else $error("serial load length wrong");
   AST_NOSHIFT: assert property (w_edge && !ld_n && !sen_n == 1'b0 |=> $stable(st.cnt))
      else $error("serial bit taken with shift enable high");
   AST_MEMWR: assert property (mem_w |=> mem_write && $stable(st.cnt) ##1 !mem_write)
      else $error("memory write disturbed the serial sequence");
   AST_INVALID: assert property (ser && st.cnt == '0 |=> !almost_empty_valid && !almost_full_valid)
      else $error("flags valid during a serial load");
   AST_AF: assert property ($rose(almost_full_valid) |->
      $past(st.af_cnt) == 2'h1 && $past(w_edge))
      else $error("full flag valid at the wrong write edge");
   AST_AE: assert property ($rose(almost_empty_valid) |->
      $past(st.ae_cnt) == 2'h1 && $past(r_edge))
      else $error("empty flag valid at the wrong read edge");
   AST_NOP: assert property (wen_n && ren_n && sen_n |=>
      $stable(st.empty_off) && $stable(st.full_off) && !mem_write && !mem_read)
      else $error("operation with all enables high");
   AST_STRAP: assert property (##1 $stable(st.serial_mode))
      else $error("programming method changed after reset");
   AST_PTR: assert property ($fell(reset) |-> st.wptr == '0 && st.rptr == '0)
      else $error("pointers not at empty low after reset");
   AST_CLEAR: assert property (ser && st.cnt == '0 |=>
      st.empty_off[16:1] == '0 && st.full_off == '0)
      else $error("old offset bits survived a new serial load");
   AST_REFUSE: assert property (w_edge && !ld_n && !wen_n && ren_n && sen_n && st.serial_mode |=>
      $stable(st.wptr) && $stable(st.empty_off) && $stable(st.full_off))
      else $error("parallel offset write taken in serial method");
   AST_MEMRD: assert property (mem_r |=> mem_read ##1 !mem_read)
      else $error("memory read pulse wrong");
endmodule : ffop_offset_ctrl
`default_nettype wire

// ===== test/ffop_host_model.sv
// host model that makes the fifo write and read clock pins
`timescale 1ns/1ns
`default_nettype none
module ffop_host_model (
   // core clock
   input wire logic core_clk,
   // fifo clock pins
   output logic write_clk_pin,
   output logic read_clk_pin
);
   initial begin
      write_clk_pin = 1'b0;
      read_clk_pin = 1'b0;
   end
   // one pin clock at a time, so offset reads and writes never overlap
   // high and low phases of four core cycles stay above the oversampling minimum
   task automatic pulse(input logic wside);
      @(posedge core_clk);
      if (wside) begin
         write_clk_pin <= 1'b1;
      end else begin
         read_clk_pin <= 1'b1;
      end
      repeat (4) @(posedge core_clk);
      write_clk_pin <= 1'b0;
      read_clk_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : pulse
endmodule : ffop_host_model
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the flag offset programming block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam logic [3:0] PWR = 4'h3, PRD = 4'h5, SHF = 4'h6, NOP = 4'hF;
   localparam logic [3:0] MWR = 4'hB, MRD = 4'hD, HLD = 4'h7;
   logic core_clk = 1'b0, reset = 1'b1, strap = 1'b0, si = 1'b0;
   logic [3:0] en = 4'hF;
   logic [17:0] din = 18'h0, dout, mwd, mw_last, dv;
   logic mw, mr, ae_v, af_v, wclk, rclk, wr = 1'b0, rd = 1'b0, wreq;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q, cfg;
   logic [33:0] sb;
   logic [17:0] pd [4];
   int error_cnt = 0, n_tests = 0, mw_cnt = 0, mr_cnt = 0, cyc = 0, mc, n;

   always #10 core_clk = ~core_clk;

   ffop_host_model u_host (.core_clk(core_clk), .write_clk_pin(wclk), .read_clk_pin(rclk));
   ffop_offset_ctrl u_dut (.core_clk(core_clk), .reset(reset), .serial_mode_strap(strap),
      .write_clk_pin(wclk), .read_clk_pin(rclk), .offset_load_select_n(en[3]),
      .write_enable_n(en[2]), .read_enable_n(en[1]), .serial_shift_enable_n(en[0]),
      .serial_in(si), .data_inputs(din), .data_outputs(dout), .mem_write(mw),
      .mem_write_data(mwd), .mem_read(mr), .almost_empty_valid(ae_v),
      .almost_full_valid(af_v), .address(addr), .read(rd), .write(wr), .writedata(wdat),
      .readdata(rdat), .waitrequest(wreq));

   // pulse counters, and a hang guard far beyond the roughly one thousand cycles needed
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (mw === 1'b1) begin
         mw_cnt <= mw_cnt + 1;
         mw_last <= mwd;
      end
      if (mr === 1'b1) mr_cnt <= mr_cnt + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task test_done;
      $display("errors %0d comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   // avalon master: hold the request until waitrequest is sampled low
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdat <= d;
      do begin
         @(posedge core_clk);
      end while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task step(input logic [3:0] e, input logic wside, input logic b);
      @(posedge core_clk);
      dv = 18'($urandom);
      en <= e;
      si <= b;
      din <= dv;
      u_host.pulse(wside);
   endtask : step

   task rst(input logic s);
      @(posedge core_clk);
      reset <= 1'b1;
      strap <= s;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : rst

   function automatic logic [17:0] part(input logic [16:0] e, f, input int i);
      logic [16:0] r;
      r = (i < 2) ? e : f;
      part = i[0] ? 18'(r[16:8]) : 18'(r[7:0]);
   endfunction : part

   // flag timing, register view and parallel readback of a finished load
   task flags(input logic [16:0] e, f);
      chk(32'(af_v), 32'h0);
      step(NOP, 1'b1, 1'b0);
      chk(32'(af_v), 32'h0);
      step(NOP, 1'b1, 1'b0);
      chk(32'(af_v), 32'h1);
      bus(1'b0, ffop_pkg::ADDR_EMPTY_OFFSET, 32'h0);
      chk(q, 32'(e));
      bus(1'b0, ffop_pkg::ADDR_FULL_OFFSET, 32'h0);
      chk(q, 32'(f));
      for (int i = 0; i < 4; i++) begin
         step(PRD, 1'b0, 1'b0);
         chk(32'(dout), 32'(part(e, f, i)));
         if (i < 2) chk(32'(ae_v), 32'(i));
      end
   endtask : flags

   initial begin
      void'($urandom(32'h0DB8));
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      repeat (4) @(posedge core_clk);
      bus(1'b0, ffop_pkg::ADDR_CONFIG, 32'h0);
      chk(q, 32'(ffop_pkg::CFG_RESET));
      bus(1'b0, 4'h1, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, ffop_pkg::ADDR_STATUS, 32'h0);
      chk(32'(q[ffop_pkg::ST_SERIAL_MODE]), 32'h0);
      // a stray part before master reset must not shift the part order
      step(PWR, 1'b1, 1'b0);
      rst(1'b0);
      for (int i = 0; i < 4; i++) begin
         step(PWR, 1'b1, 1'b0);
         pd[i] = dv;
      end
      flags({pd[1][16:8], pd[0][7:0]}, {pd[3][16:8], pd[2][7:0]});
      mc = mr_cnt;
      step(MWR, 1'b1, 1'b0);
      chk(32'(mw_last), 32'(dv));
      step(MRD, 1'b0, 1'b0);
      chk(32'(mr_cnt), 32'(mc + 1));
      mc = mw_cnt + mr_cnt;
      step(NOP, 1'b1, 1'b0);
      step(NOP, 1'b0, 1'b0);
      chk(32'(mw_cnt + mr_cnt), 32'(mc));
      // a serial shift in the parallel method must leave the bit count alone
      step(SHF, 1'b1, 1'b1);
      bus(1'b0, ffop_pkg::ADDR_STATUS, 32'h0);
      chk(32'(q[ffop_pkg::ST_COUNT_LO +: 6]), 32'h0);
      rst(1'b1);
      bus(1'b0, ffop_pkg::ADDR_STATUS, 32'h0);
      chk(32'(q[ffop_pkg::ST_SERIAL_MODE]), 32'h1);
      for (int p = 0; p < 2; p++) begin
         cfg = ($urandom & 32'h17) | 32'h08;
         bus(1'b1, ffop_pkg::ADDR_CONFIG, cfg);
         n = 13 + int'(cfg[2:1]) + int'(cfg[0]);
         sb = 34'({$urandom, $urandom});
         for (int b = 0; b < 2 * n; b++) begin
            if (b == 10) begin
               mc = mw_cnt;
               step(MWR, 1'b1, 1'b0);
               chk(32'(mw_cnt), 32'(mc + 1));
               chk(32'(mw_last), 32'(dv));
               step(HLD, 1'b1, ~sb[b]);
               step(PWR, 1'b1, 1'b0);
            end
            if (b == 2 * n - 1) chk(32'({ae_v, af_v}), 32'h0);
            step(SHF, 1'b1, sb[b]);
         end
         flags(17'(sb & ((34'h1 << n) - 34'h1)), 17'((sb >> n) & ((34'h1 << n) - 34'h1)));
      end
      test_done();
   end
endmodule : testbench
`default_nettype wire
